// ---- hdl/dsp_multiplier_block.v ----
// Four-unit 18x18 multiplier block with adder, accumulator and shift chain
`include "dsp_multiplier_block_regs.vh"

// How it works
// - Each half runs simple, accumulate or two-adder mode; four-adder mode is set by the upper half select only.
// - Simple mode gives eight 9x9, four 18x18 or one 36x36 products.
// - Accumulation only at 18x18, two independent 52-bit accumulators.
// - Two-adder mode sums product pairs: four 9x9 sums or two 18x18.
// - Upper and lower halves take modes and operand sizes independently.
// - Operand input registers form a shift chain passed row to row.
// - The last row of the chain is driven out of the block.
// - Four units, each a full 18x18 multiplier, 36 in and 36 out.
// - Four independent clear and enable sets, one for each row.
// - Rounding and saturation follow the Q1.15 format.
// - The 36x36 product is exact for any operand signedness.
module dsp_multiplier_block #(
	parameter W = `OPERAND_W
) (
	// Clock and reset
	input wire core_clk,
	input wire reset,
	// Operands, row k in bits [18k+17:18k]
	input wire [4*W-1:0] operand_a,
	input wire [4*W-1:0] operand_b,
	input wire sign_a,
	input wire sign_b,
	// Shift chain
	input wire [W-1:0] shift_in_a,
	input wire [W-1:0] shift_in_b,
	input wire [3:0] shift_source_a,
	input wire [3:0] shift_source_b,
	output reg [W-1:0] shift_out_a,
	output reg [W-1:0] shift_out_b,
	// Per-row clear and enable sets
	input wire async_clear_set_zero,
	input wire async_clear_set_one,
	input wire async_clear_set_two,
	input wire async_clear_set_three,
	input wire clock_enable_set_zero,
	input wire clock_enable_set_one,
	input wire clock_enable_set_two,
	input wire clock_enable_set_three,
	// Mode and arithmetic controls
	input wire [1:0] upper_half_mode_select,
	input wire [1:0] lower_half_mode_select,
	input wire upper_half_split9,
	input wire lower_half_split9,
	input wire full_width_36,
	input wire add_subtract_select_upper,
	input wire add_subtract_select_lower,
	input wire first_pair_product_round,
	input wire first_pair_product_saturate,
	input wire second_pair_product_round,
	input wire second_pair_product_saturate,
	input wire accum_load_upper,
	input wire accum_load_lower,
	// Results
	output reg [71:0] result_upper,
	output reg [71:0] result_lower
);

	// ------------------------------------------------------------------
	// Arithmetic helpers
	// ------------------------------------------------------------------
	// Sign bit is the operand MSB only when that operand is signed
	function signed [37:0] mul18;
		input [17:0] x;
		input [17:0] y;
		input sx;
		input sy;
		reg signed [18:0] ex;
		reg signed [18:0] ey;
		begin
			ex = $signed({sx & x[17], x});
			ey = $signed({sy & y[17], y});
			mul18 = ex * ey;
		end
	endfunction

	function signed [19:0] mul9;
		input [8:0] x;
		input [8:0] y;
		input sx;
		input sy;
		reg signed [9:0] ex;
		reg signed [9:0] ey;
		begin
			ex = $signed({sx & x[8], x});
			ey = $signed({sy & y[8], y});
			mul9 = ex * ey;
		end
	endfunction

	// Q1.15 x Q1.15: only -1 * -1 overflows, round at bit 14
	function signed [37:0] q15_fix;
		input signed [37:0] p;
		input rnd;
		input sat;
		reg signed [37:0] s;
		begin
			s = (sat && p == `Q15_SAT_IN) ? `Q15_SAT_OUT : p;
			q15_fix = rnd ? ((s + `Q15_ROUND_ADD) & `Q15_ROUND_MASK) : s;
		end
	endfunction

	// ------------------------------------------------------------------
	// Row control sets
	// ------------------------------------------------------------------
	wire [3:0] row_clear;
	wire [3:0] row_enable;
	assign row_clear = {async_clear_set_three, async_clear_set_two,
		async_clear_set_one, async_clear_set_zero};
	assign row_enable = {clock_enable_set_three, clock_enable_set_two,
		clock_enable_set_one, clock_enable_set_zero};

	// ------------------------------------------------------------------
	// Input registers and shift chain
	// ------------------------------------------------------------------
	reg [4*W-1:0] a_q;
	reg [4*W-1:0] b_q;
	wire [4*W-1:0] prev_a;
	wire [4*W-1:0] prev_b;
	integer k;

	// Each row can take the row above instead of its own operand
	assign prev_a = {a_q[3*W-1:0], shift_in_a};
	assign prev_b = {b_q[3*W-1:0], shift_in_b};

	// Clear beats enable so a row can be flushed while stalled
	always @(posedge core_clk or posedge reset) begin
		if (reset) begin
			a_q <= {4*W{1'b0}};
			b_q <= {4*W{1'b0}};
			shift_out_a <= {W{1'b0}};
			shift_out_b <= {W{1'b0}};
		end else begin
			for (k = 0; k < 4; k = k + 1) begin
				if (row_clear[k]) begin
					a_q[k*W +: W] <= {W{1'b0}};
					b_q[k*W +: W] <= {W{1'b0}};
				end else if (row_enable[k]) begin
					a_q[k*W +: W] <= shift_source_a[k] ?
						prev_a[k*W +: W] : operand_a[k*W +: W];
					b_q[k*W +: W] <= shift_source_b[k] ?
						prev_b[k*W +: W] : operand_b[k*W +: W];
				end
			end
			// Chain end leaves the block to reach other columns
			if (row_clear[3]) begin
				shift_out_a <= {W{1'b0}};
				shift_out_b <= {W{1'b0}};
			end else if (row_enable[3]) begin
				shift_out_a <= shift_source_a[3] ? prev_a[3*W +: W] :
					operand_a[3*W +: W];
				shift_out_b <= shift_source_b[3] ? prev_b[3*W +: W] :
					operand_b[3*W +: W];
			end
		end
	end

	// ------------------------------------------------------------------
	// Four multiplier units
	// ------------------------------------------------------------------
	wire [4*38-1:0] p18;
	wire [4*20-1:0] p9_hi;
	wire [4*20-1:0] p9_lo;
	genvar u;
	generate
		for (u = 0; u < 4; u = u + 1) begin : unit
			wire rnd;
			wire sat;
			assign rnd = (u < 2) ? first_pair_product_round :
				second_pair_product_round;
			assign sat = (u < 2) ? first_pair_product_saturate :
				second_pair_product_saturate;
			// Full 18x18 unit, Q1.15 fix-up applied here
			assign p18[u*38 +: 38] = q15_fix(mul18(a_q[u*W +: W],
				b_q[u*W +: W], sign_a, sign_b), rnd, sat);
			// Same unit split into two 9x9 multipliers
			assign p9_hi[u*20 +: 20] = mul9(a_q[u*W+9 +: 9],
				b_q[u*W+9 +: 9], sign_a, sign_b);
			assign p9_lo[u*20 +: 20] = mul9(a_q[u*W +: 9],
				b_q[u*W +: 9], 1'b0, 1'b0);
		end
	endgenerate

	// 36x36 built from rows 0 and 1, exact for any signedness
	wire signed [36:0] a36;
	wire signed [36:0] b36;
	wire signed [73:0] p36;
	assign a36 = $signed({sign_a & a_q[2*W-1], a_q[2*W-1:0]});
	assign b36 = $signed({sign_b & b_q[2*W-1], b_q[2*W-1:0]});
	assign p36 = a36 * b36;

	// ------------------------------------------------------------------
	// Per-half adders and accumulators
	// ------------------------------------------------------------------
	reg [2*`ACC_W-1:0] acc;
	wire [2*`ACC_W-1:0] acc_next;
	wire [2*72-1:0] half_res;
	wire [2*39-1:0] sum2;
	wire [2*21-1:0] sum9_hi;
	wire [2*21-1:0] sum9_lo;
	genvar h;
	generate
		for (h = 0; h < 2; h = h + 1) begin : half
			wire [1:0] mode;
			wire split;
			wire add;
			wire load;
			wire signed [37:0] q0;
			wire signed [37:0] q1;
			wire signed [38:0] s2;
			wire signed [20:0] shi;
			wire signed [20:0] slo;
			wire signed [`ACC_W-1:0] term;
			reg [71:0] r;
			assign mode = h ? lower_half_mode_select :
				upper_half_mode_select;
			assign split = h ? lower_half_split9 : upper_half_split9;
			assign add = h ? add_subtract_select_lower :
				add_subtract_select_upper;
			assign load = h ? accum_load_lower : accum_load_upper;
			assign q0 = p18[(2*h)*38 +: 38];
			assign q1 = p18[(2*h+1)*38 +: 38];
			// Pair sums, add when the select is high
			assign s2 = add ? q0 + q1 : q0 - q1;
			assign shi = add ?
				$signed(p9_hi[(2*h)*20 +: 20]) + $signed(p9_hi[(2*h+1)*20 +: 20]) :
				$signed(p9_hi[(2*h)*20 +: 20]) - $signed(p9_hi[(2*h+1)*20 +: 20]);
			assign slo = add ?
				$signed(p9_lo[(2*h)*20 +: 20]) + $signed(p9_lo[(2*h+1)*20 +: 20]) :
				$signed(p9_lo[(2*h)*20 +: 20]) - $signed(p9_lo[(2*h+1)*20 +: 20]);
			assign sum2[h*39 +: 39] = s2;
			assign sum9_hi[h*21 +: 21] = shi;
			assign sum9_lo[h*21 +: 21] = slo;
			// Accumulator always works at 18x18, split is ignored
			assign term = {{13{s2[38]}}, s2};
			assign acc_next[h*`ACC_W +: `ACC_W] = load ? term :
				acc[h*`ACC_W +: `ACC_W] + term;
			always @* begin
				case (mode)
				`MODE_SIMPLE: r = split ?
					{p9_hi[(2*h+1)*20 +: 18], p9_lo[(2*h+1)*20 +: 18],
					p9_hi[(2*h)*20 +: 18], p9_lo[(2*h)*20 +: 18]} :
					{q1[35:0], q0[35:0]};
				`MODE_MAC: r = {{20{acc_next[h*`ACC_W+`ACC_W-1]}},
					acc_next[h*`ACC_W +: `ACC_W]};
				`MODE_TWO_ADD: r = split ?
					{{15{shi[20]}}, shi, {15{slo[20]}}, slo} :
					{{33{s2[38]}}, s2};
				default: r = 72'h000000000000000000;
				endcase
			end
			assign half_res[h*72 +: 72] = r;
		end
	endgenerate

	// Four-product sums reuse the two pair sums of both halves
	wire signed [39:0] sum4;
	wire signed [21:0] sum4_hi;
	wire signed [21:0] sum4_lo;
	wire [71:0] four_res;
	assign sum4 = $signed(sum2[38:0]) + $signed(sum2[77:39]);
	assign sum4_hi = $signed(sum9_hi[20:0]) + $signed(sum9_hi[41:21]);
	assign sum4_lo = $signed(sum9_lo[20:0]) + $signed(sum9_lo[41:21]);
	assign four_res = upper_half_split9 ?
		{{14{sum4_hi[21]}}, sum4_hi, {14{sum4_lo[21]}}, sum4_lo} :
		{{32{sum4[39]}}, sum4};

	wire four_mode;
	assign four_mode = upper_half_mode_select == `MODE_FOUR_ADD;

	// ------------------------------------------------------------------
	// Output registers, upper on row 1 set, lower on row 3 set
	// ------------------------------------------------------------------
	// 36x36 bypasses the adders; any post-add is left to the fabric
	always @(posedge core_clk or posedge reset) begin
		if (reset) begin
			result_upper <= 72'h000000000000000000;
			result_lower <= 72'h000000000000000000;
			acc <= {2*`ACC_W{1'b0}};
		end else begin
			if (row_clear[1]) begin
				result_upper <= 72'h000000000000000000;
				acc[`ACC_W-1:0] <= {`ACC_W{1'b0}};
			end else if (row_enable[1]) begin
				if (full_width_36)
					result_upper <= p36[71:0];
				else if (four_mode)
					result_upper <= four_res;
				else
					result_upper <= half_res[71:0];
				if (!full_width_36 && !four_mode &&
					upper_half_mode_select == `MODE_MAC)
					acc[`ACC_W-1:0] <= acc_next[`ACC_W-1:0];
			end
			if (row_clear[3]) begin
				result_lower <= 72'h000000000000000000;
				acc[2*`ACC_W-1:`ACC_W] <= {`ACC_W{1'b0}};
			end else if (row_enable[3]) begin
				if (full_width_36 || four_mode)
					result_lower <= 72'h000000000000000000;
				else
					result_lower <= half_res[143:72];
				if (!full_width_36 && !four_mode &&
					lower_half_mode_select == `MODE_MAC)
					acc[2*`ACC_W-1:`ACC_W] <= acc_next[2*`ACC_W-1:`ACC_W];
			end
		end
	end

endmodule // dsp_multiplier_block

// ---- hdl/dsp_multiplier_block_regs.vh ----
// Mode codes and Q1.15 constants for the DSP multiplier block
`ifndef DSP_MULTIPLIER_BLOCK_REGS_VH
`define DSP_MULTIPLIER_BLOCK_REGS_VH

// ----------------------------------------------------------------------
// Per-half mode select encodings
// ----------------------------------------------------------------------
`define MODE_SIMPLE 2'h0
`define MODE_MAC 2'h1
`define MODE_TWO_ADD 2'h2
`define MODE_FOUR_ADD 2'h3

// ----------------------------------------------------------------------
// Widths and Q1.15 round/saturate constants (on 38-bit products)
// ----------------------------------------------------------------------
`define OPERAND_W 18
`define ACC_W 52
`define Q15_ROUND_ADD 38'h0000004000
`define Q15_ROUND_MASK 38'h3FFFFF8000
`define Q15_SAT_IN 38'h0040000000
`define Q15_SAT_OUT 38'h003FFFFFFF

`endif

// ---- verification/dsp_multiplier_block_tb.sv ----
// Self-checking bench for the DSP multiplier block
`include "dsp_multiplier_block_regs.vh"
module dsp_multiplier_block_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam [71:0] A = {18'h12345, 18'h00003, 18'h2AAAA, 18'h3FFFF};
	localparam [71:0] B = {18'h00002, 18'h03000, 18'h35555, 18'h3FFFF};
	logic core_clk = 0, reset = 1, sign_a = 0, sign_b = 0, fab_add = 0;
	logic [71:0] operand_a = '0, operand_b = '0;
	logic [17:0] shift_in_a = '0, shift_in_b = '0;
	logic [3:0] shift_source_a = '0, shift_source_b = '0;
	logic async_clear_set_zero = 0, async_clear_set_one = 0;
	logic async_clear_set_two = 0, async_clear_set_three = 0;
	logic clock_enable_set_zero = 1, clock_enable_set_one = 1;
	logic clock_enable_set_two = 1, clock_enable_set_three = 1;
	logic [1:0] upper_half_mode_select = 0, lower_half_mode_select = 0;
	logic upper_half_split9 = 0, lower_half_split9 = 0, full_width_36 = 0;
	logic add_subtract_select_upper = 1, add_subtract_select_lower = 1;
	logic first_pair_product_round = 0, first_pair_product_saturate = 0;
	logic second_pair_product_round = 0, second_pair_product_saturate = 0;
	logic accum_load_upper = 0, accum_load_lower = 0;
	wire [17:0] shift_out_a, shift_out_b;
	wire [71:0] result_upper, result_lower, fab_sum;
	int n_errors = 0, compares = 0;
	dsp_multiplier_block dut_u (.*);
	fabric_model fab_u (.core_clk, .reset, .add_en(fab_add),
		.product(result_upper), .sum(fab_sum));
	initial forever #20 core_clk = ~core_clk;
	// Expected unit products, worked out from the operand tables
	function automatic [35:0] p(input int k, s);
		logic signed [35:0] r;
		r = $signed(A[18*k+:18]) * $signed(B[18*k+:18]);
		p = s ? r : A[18*k+:18] * B[18*k+:18];
	endfunction
	function automatic [35:0] q(input int k, h);
		q = A[18*k+9*h+:9] * B[18*k+9*h+:9];
	endfunction
	function automatic [35:0] s9(input int k0, k1, h);
		s9 = 0;
		for (int k = k0; k <= k1; k++)
			s9 += q(k, h);
	endfunction
	task automatic chk(input [71:0] got, exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Operands in, two edges to the result, then compare
	task automatic run(input [71:0] a, b, eu, el);
		operand_a = a;
		operand_b = b;
		repeat (2) @(negedge core_clk);
		chk(result_upper, eu);
		chk(result_lower, el);
	endtask
	task automatic cfg(input [1:0] um, lm, input s9, w);
		upper_half_mode_select = um;
		lower_half_mode_select = lm;
		upper_half_split9 = s9;
		lower_half_split9 = s9;
		full_width_36 = w;
	endtask
	task automatic t_ctrl();
		cfg(`MODE_SIMPLE, `MODE_SIMPLE, 0, 0);
		run(A, B, {p(1, 0), p(0, 0)}, {p(3, 0), p(2, 0)});
		{clock_enable_set_zero, clock_enable_set_one,
			clock_enable_set_two, clock_enable_set_three} = 4'h0;
		run(0, 0, {p(1, 0), p(0, 0)}, {p(3, 0), p(2, 0)});
		// Clear must win over the enables coming back
		{clock_enable_set_zero, clock_enable_set_one,
			clock_enable_set_two, clock_enable_set_three} = 4'hF;
		{async_clear_set_zero, async_clear_set_one,
			async_clear_set_two, async_clear_set_three} = 4'hF;
		run(A, B, 0, 0);
		{async_clear_set_zero, async_clear_set_one,
			async_clear_set_two, async_clear_set_three} = 4'h0;
	endtask
	task automatic t_simple();
		for (int s = 0; s < 2; s++) begin
			sign_a = s[0];
			sign_b = s[0];
			run(A, B, {p(1, s), p(0, s)}, {p(3, s), p(2, s)});
		end
		// Signed Q1.15: 0x8000 squared saturates, lower pair rounds
		first_pair_product_saturate = 1;
		second_pair_product_round = 1;
		run({18'h12345, 18'h00003, 18'h0, 18'h38000},
			{18'h00002, 18'h03000, 18'h0, 18'h38000}, {36'h0, 36'h03FFFFFFF},
			{36'h000028000, 36'h000008000});
		// Same fix-ups swapped onto the other pairs
		first_pair_product_saturate = 0;
		second_pair_product_round = 0;
		first_pair_product_round = 1;
		second_pair_product_saturate = 1;
		run({18'h38000, 18'h0, 18'h00003, 18'h12345},
			{18'h38000, 18'h0, 18'h03000, 18'h00002},
			{36'h000008000, 36'h000028000},
			{36'h03FFFFFFF, 36'h0});
		first_pair_product_round = 0;
		second_pair_product_saturate = 0;
	endtask
	task automatic t_adders();
		logic [71:0] e;
		sign_a = 0;
		sign_b = 0;
		add_subtract_select_upper = 0;
		add_subtract_select_lower = 0;
		cfg(`MODE_TWO_ADD, `MODE_TWO_ADD, 0, 0);
		run(A, B, p(0, 0) - p(1, 0), p(2, 0) - p(3, 0));
		add_subtract_select_upper = 1;
		add_subtract_select_lower = 1;
		cfg(`MODE_TWO_ADD, `MODE_TWO_ADD, 1, 0);
		run(A, B, {s9(0, 1, 1), s9(0, 1, 0)},
			{s9(2, 3, 1), s9(2, 3, 0)});
		cfg(`MODE_FOUR_ADD, `MODE_SIMPLE, 0, 0);
		e = p(0, 0) + p(1, 0) + p(2, 0) + p(3, 0);
		run(A, B, e, 0);
		cfg(`MODE_FOUR_ADD, `MODE_SIMPLE, 1, 0);
		run(A, B, {s9(0, 3, 1), s9(0, 3, 0)}, 0);
	endtask
	task automatic t_mixed();
		logic [71:0] e;
		cfg(`MODE_SIMPLE, `MODE_MAC, 0, 0);
		upper_half_split9 = 1;
		accum_load_lower = 1;
		e = p(2, 0) + p(3, 0);
		run(A, B, {18'(q(1, 1)), 18'(q(1, 0)), 18'(q(0, 1)), 18'(q(0, 0))},
			e);
		accum_load_lower = 0;
		for (int i = 2; i < 4; i++) begin
			@(negedge core_clk);
			chk(result_lower, e * i);
		end
		// Halves swapped: upper accumulates, lower runs split simple
		cfg(`MODE_MAC, `MODE_SIMPLE, 0, 0);
		lower_half_split9 = 1;
		accum_load_upper = 1;
		e = p(0, 0) + p(1, 0);
		run(A, B, e, {18'(q(3, 1)), 18'(q(3, 0)), 18'(q(2, 1)),
			18'(q(2, 0))});
		accum_load_upper = 0;
		@(negedge core_clk);
		chk(result_upper, e * 2);
	endtask
	task automatic t_wide();
		logic [71:0] x, y, t;
		t = 0;
		cfg(`MODE_SIMPLE, `MODE_SIMPLE, 0, 1);
		for (int s = 0; s < 4; s++) begin
			sign_a = s[1];
			sign_b = s[0];
			x = {{36{s[1] & A[35]}}, A[35:0]};
			y = {{36{s[0] & B[35]}}, B[35:0]};
			run(A, B, x * y, 0);
			t += x * y;
			fab_add = 1;
			@(negedge core_clk);
			fab_add = 0;
		end
		chk(fab_sum, t);
		full_width_36 = 0;
	endtask
	task automatic t_chain();
		logic [17:0] v;
		shift_source_a = 4'hF;
		shift_source_b = 4'hF;
		for (int i = 0; i < 8; i++) begin
			shift_in_a = 18'(i * 7 + 1);
			shift_in_b = ~shift_in_a;
			@(negedge core_clk);
			// Chain end shadows row 3, three edges behind row 0
			v = 18'(i * 7 - 20);
			if (i > 2) begin
				chk({54'h0, shift_out_a}, {54'h0, v});
				chk({54'h0, shift_out_b}, {54'h0, ~v});
			end
		end
	endtask
	task automatic finish_test();
		if (n_errors == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		repeat (5) @(negedge core_clk);
		reset = 0;
		chk(result_upper, 0);
		t_ctrl();
		t_simple();
		t_adders();
		t_mixed();
		t_wide();
		t_chain();
		finish_test();
	end
endmodule // dsp_multiplier_block_tb

// ---- verification/dsp_props.sv ----
// Port-level assertions for the DSP multiplier block
`include "dsp_multiplier_block_regs.vh"
module dsp_props (
	// Clock, reset and signs
	input wire core_clk, reset, sign_a, sign_b,
	input wire [71:0] operand_a, operand_b,
	// Shift chain
	input wire [17:0] shift_in_a, shift_in_b, shift_out_a, shift_out_b,
	input wire [3:0] shift_source_a, shift_source_b,
	// Clear and enable sets
	input wire async_clear_set_zero, async_clear_set_one,
	input wire async_clear_set_two, async_clear_set_three,
	input wire clock_enable_set_zero, clock_enable_set_one,
	input wire clock_enable_set_two, clock_enable_set_three,
	// Modes and results
	input wire [1:0] upper_half_mode_select,
	input wire upper_half_split9, full_width_36,
	input wire first_pair_product_round, first_pair_product_saturate,
	input wire [71:0] result_upper, result_lower
);
	timeunit 1ns;
	timeprecision 1ps;
	// All rows running and none cleared
	wire run_ok = clock_enable_set_zero & clock_enable_set_one &
		clock_enable_set_two & clock_enable_set_three &
		~(async_clear_set_zero | async_clear_set_one |
		async_clear_set_two | async_clear_set_three);
	// Extended first so the product keeps all 36 bits
	wire [35:0] m0 = {18'h0, operand_a[17:0]} * {18'h0, operand_b[17:0]};
	wire [35:0] m1 = {18'h0, operand_a[35:18]} * {18'h0, operand_b[35:18]};
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	sequence s_chain;
		run_ok && (&shift_source_a) && (&shift_source_b);
	endsequence
	sequence s_simple;
		run_ok && !sign_a && !sign_b && !upper_half_split9 &&
		upper_half_mode_select == `MODE_SIMPLE && !full_width_36 &&
		!first_pair_product_round && !first_pair_product_saturate &&
		shift_source_a[1:0] == 2'h0 && shift_source_b[1:0] == 2'h0;
	endsequence
	// Chain end loads beside row 3, so it trails row 0 by three edges
	property p_chain_a;
		s_chain [*4] |=> shift_out_a == $past(shift_in_a, 4);
	endproperty
	property p_chain_b;
		s_chain [*4] |=> shift_out_b == $past(shift_in_b, 4);
	endproperty
	property p_simple;
		s_simple [*2] |=> result_upper == {$past(m1, 2), $past(m0, 2)};
	endproperty
	property p_wide_lower;
		(run_ok && full_width_36) [*2] |=> result_lower == 72'h0;
	endproperty
	property p_four_lower;
		(run_ok && upper_half_mode_select == `MODE_FOUR_ADD) [*2]
			|=> result_lower == 72'h0;
	endproperty
	property p_clear_upper;
		async_clear_set_one |=> result_upper == 72'h0;
	endproperty
	property p_clear_lower;
		async_clear_set_three |=> result_lower == 72'h0;
	endproperty
	property p_hold_upper;
		!clock_enable_set_one && !async_clear_set_one
			|=> $stable(result_upper);
	endproperty
	a_chain_a: assert property (p_chain_a)
		else $error("chain end a wrong");
	a_chain_b: assert property (p_chain_b)
		else $error("chain end b wrong");
	a_simple: assert property (p_simple)
		else $error("simple product wrong");
	a_wide_lower: assert property (p_wide_lower)
		else $error("lower result not zero in wide mode");
	a_four_lower: assert property (p_four_lower)
		else $error("lower result not zero in four-adder mode");
	a_clear_upper: assert property (p_clear_upper)
		else $error("upper result not cleared");
	a_clear_lower: assert property (p_clear_lower)
		else $error("lower result not cleared");
	a_hold_upper: assert property (p_hold_upper)
		else $error("upper result moved while disabled");
endmodule // dsp_props

bind dsp_multiplier_block dsp_props u_props (.*);

// ---- verification/fabric_model.sv ----
// Fabric-side post-adder for wide products
module fabric_model (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// Product in, running sum out
	input wire logic add_en,
	input wire logic [71:0] product,
	output logic [71:0] sum
);
	timeunit 1ns;
	timeprecision 1ps;
	// The block offers no adder at 36x36, so the fabric sums
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset)
			sum <= '0;
		else if (add_en)
			sum <= sum + product;
	end
endmodule // fabric_model
